// ==== logic/sysmove_unit.sv ====
// Call and system-register move execution unit
// Function
// - Indirect call: return reg gets own address plus four, PC from Rn
// - Call is delayed: following instruction runs before the target
// - No interrupt accepted between the call and its delay slot
// - A branch in the call's delay slot raises slot illegal
// - Status load from Rm (four cycles) or @Rm+ (done after memory ack), T equals loaded LSB
// - Status load in user mode: general or slot illegal exception
// - FP system loads from Rm (one cycle) or @Rm+ (done after memory ack) into communication or status
// - FP status loads are ANDed with the write mask, bits 22-31 zero
// - Status store to Rn (one cycle) or predecremented @-Rn (done after memory ack)
// - Status store in user mode raises illegal, stores nothing
// - FP system stores to Rn (one cycle) or predecremented @-Rn (done after memory ack)
// - FP status stores are masked with the write mask
// - Memory forms report TLB faults and address error; stores page write
// - FP status bits 19, 18, 21, 0 give precision, denormal, bank, rounding
module sysmove_unit #(
    parameter int STATUS_LOAD_CYCLES = sysmove_pkg::STATUS_LOAD_CYCLES,
    parameter logic [31:0] STATUS_RESET = sysmove_pkg::STATUS_RESET
) (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic i_VALID,
    input wire logic [15:0] i_OPCODE,
    input wire logic [31:0] i_PC,
    input wire logic [31:0] i_REG_DATA,
    input wire logic i_IS_BRANCH,
    input wire logic i_MEM_ACK,
    input wire logic [31:0] i_MEM_RDATA,
    input wire sysmove_pkg::fault_t i_MEM_FAULT,
    output logic o_READY,
    output logic o_DONE,
    output logic o_GR_WE,
    output logic [3:0] o_GR_IDX,
    output logic [31:0] o_GR_DATA,
    output logic o_PC_LOAD,
    output logic [31:0] o_PC_TARGET,
    output logic o_INT_BLOCK,
    output sysmove_pkg::exc_t o_EXC,
    output logic o_MEM_REQ,
    output logic o_MEM_WE,
    output logic [31:0] o_MEM_ADDR,
    output logic [31:0] o_MEM_WDATA,
    output logic [31:0] o_STATUS,
    output logic [31:0] o_PROC_RETURN,
    output logic [31:0] o_FP_COMM,
    output logic [31:0] o_FP_STATUS,
    output sysmove_pkg::fp_mode_t o_FP_MODE
);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_MEM = 3'b100
    } state_t;

    typedef struct packed {
        state_t state;
        logic [2:0] cnt;
        logic in_slot;
        logic [31:0] status_reg;
        logic [31:0] procedure_return_reg;
        logic [31:0] fp_communication_reg;
        logic [31:0] fp_status_control_reg;
        logic done;
        logic gr_we;
        logic [3:0] gr_idx;
        logic [31:0] gr_data;
        logic pc_load;
        logic [31:0] pc_target;
        sysmove_pkg::exc_t exc;
        logic mem_req;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        sysmove_pkg::dec_t op;
        logic [31:0] base_new;
    } st_t;

    // Counter holds the load time minus two in three bits, needs a busy phase
    if (STATUS_LOAD_CYCLES < 2 || STATUS_LOAD_CYCLES > 9) begin
        $error("STATUS_LOAD_CYCLES must lie between 2 and 9");
    end

    localparam logic [2:0] HOLD_LOAD = 3'(STATUS_LOAD_CYCLES - 2);

    logic rst_meta;
    logic rst_n;
    st_t s;
    st_t next_s;
    sysmove_pkg::dec_t dec;
    logic accept;
    logic user_mode;
    logic [31:0] addr;
    sysmove_pkg::fault_t fault;

    // Reset released through two flops; assertion stays asynchronous
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    sysmove_decode sysmove_decode_inst (
        .i_opcode(i_OPCODE),
        .o_dec(dec)
    );

    // Value a store form writes; FP status always leaves masked
    function automatic logic [31:0] store_value(
        input st_t cur, input sysmove_pkg::op_kind_t k);
        store_value = cur.status_reg;
        if (k == sysmove_pkg::OP_STORE_COMM) begin
            store_value = cur.fp_communication_reg;
        end else if (k == sysmove_pkg::OP_STORE_FPSTAT) begin
            store_value = cur.fp_status_control_reg &
                          sysmove_pkg::FP_STATUS_WRITE_MASK;
        end
    endfunction

    assign accept = i_VALID && o_READY;
    assign user_mode = !s.status_reg[sysmove_pkg::STATUS_MODE_BIT];
    // Longword address: predecrement for stores, plain base for loads
    assign addr = dec.store ? i_REG_DATA - sysmove_pkg::WORD_BYTES
                            : i_REG_DATA;
    // page write checked only for stores
    assign fault = '{multi_hit: i_MEM_FAULT.multi_hit,
                     miss: i_MEM_FAULT.miss,
                     protect: i_MEM_FAULT.protect,
                     init_write: i_MEM_FAULT.init_write && s.op.store};

    // Next-state logic; pulse outputs fall back to zero each cycle
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.gr_we = 1'b0;
        next_s.pc_load = 1'b0;
        next_s.exc = '0;
        unique case (s.state)
            ST_IDLE: begin
                if (accept) begin
                    // slot ends with the next accepted instruction
                    next_s.in_slot = 1'b0;
                    next_s.done = 1'b1;
                    next_s.op = dec;
                    if (s.in_slot && (i_IS_BRANCH ||
                        dec.kind == sysmove_pkg::OP_CALL)) begin
                        next_s.exc.slot_illegal = 1'b1;
                    end else if (dec.priv && user_mode) begin
                        next_s.exc.slot_illegal = s.in_slot;
                        next_s.exc.gen_illegal = !s.in_slot;
                    end else if (dec.mem) begin
                        next_s.base_new = dec.store ? addr
                            : i_REG_DATA + sysmove_pkg::WORD_BYTES;
                        if (addr[1:0] != 2'h0) begin
                            next_s.exc.addr_err = 1'b1;
                        end else begin
                            next_s.done = 1'b0;
                            next_s.state = ST_MEM;
                            next_s.mem_req = 1'b1;
                            next_s.mem_we = dec.store;
                            next_s.mem_addr = addr;
                            next_s.mem_wdata = store_value(s, dec.kind);
                        end
                    end else begin
                        unique case (dec.kind)
                            sysmove_pkg::OP_CALL: begin
                                next_s.procedure_return_reg =
                                    i_PC + sysmove_pkg::RETURN_OFFSET;
                                next_s.pc_load = 1'b1;
                                next_s.pc_target = i_REG_DATA;
                                next_s.in_slot = 1'b1;
                            end
                            // T bit rides in bit 0 of the copy
                            sysmove_pkg::OP_LOAD_STATUS: begin
                                next_s.status_reg = i_REG_DATA;
                                next_s.done = 1'b0;
                                next_s.state = ST_HOLD;
                                next_s.cnt = HOLD_LOAD;
                            end
                            sysmove_pkg::OP_LOAD_COMM: begin
                                next_s.fp_communication_reg = i_REG_DATA;
                            end
                            sysmove_pkg::OP_LOAD_FPSTAT: begin
                                next_s.fp_status_control_reg = i_REG_DATA &
                                    sysmove_pkg::FP_STATUS_WRITE_MASK;
                            end
                            sysmove_pkg::OP_STORE_STATUS,
                            sysmove_pkg::OP_STORE_COMM,
                            sysmove_pkg::OP_STORE_FPSTAT: begin
                                next_s.gr_we = 1'b1;
                                next_s.gr_idx = dec.reg_idx;
                                next_s.gr_data = store_value(s, dec.kind);
                            end
                            default: begin
                                next_s.op = dec;
                            end
                        endcase
                    end
                end
            end
            // status load occupies the unit for its full time
            ST_HOLD: begin
                next_s.cnt = s.cnt - 3'h1;
                if (s.cnt == 3'h0) begin
                    next_s.state = ST_IDLE;
                    next_s.done = 1'b1;
                end
            end
            ST_MEM: begin
                if (i_MEM_ACK) begin
                    next_s.mem_req = 1'b0;
                    next_s.state = ST_IDLE;
                    next_s.done = 1'b1;
                    if (fault != '0) begin
                        next_s.exc.multi_hit = fault.multi_hit;
                        next_s.exc.miss = fault.miss;
                        next_s.exc.protect = fault.protect;
                        next_s.exc.init_write = fault.init_write;
                    end else begin
                        next_s.gr_we = 1'b1;
                        next_s.gr_idx = s.op.reg_idx;
                        next_s.gr_data = s.base_new;
                        if (s.op.kind == sysmove_pkg::OP_LOAD_STATUS) begin
                            next_s.status_reg = i_MEM_RDATA;
                        end else if (s.op.kind ==
                                     sysmove_pkg::OP_LOAD_COMM) begin
                            next_s.fp_communication_reg = i_MEM_RDATA;
                        end else if (s.op.kind ==
                                     sysmove_pkg::OP_LOAD_FPSTAT) begin
                            // mask on FP status memory load
                            next_s.fp_status_control_reg = i_MEM_RDATA &
                                sysmove_pkg::FP_STATUS_WRITE_MASK;
                        end
                    end
                end
            end
            default: begin
                next_s.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge I_MCLK or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{state: ST_IDLE, status_reg: STATUS_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    // Ready is combinational so a new instruction can follow at once
    assign o_READY = s.state == ST_IDLE;
    assign o_DONE = s.done;
    assign o_GR_WE = s.gr_we;
    assign o_GR_IDX = s.gr_idx;
    assign o_GR_DATA = s.gr_data;
    assign o_PC_LOAD = s.pc_load;
    assign o_PC_TARGET = s.pc_target;
    // interrupt hold while the slot is pending
    assign o_INT_BLOCK = s.in_slot;
    assign o_EXC = s.exc;
    assign o_MEM_REQ = s.mem_req;
    assign o_MEM_WE = s.mem_we;
    assign o_MEM_ADDR = s.mem_addr;
    assign o_MEM_WDATA = s.mem_wdata;
    assign o_STATUS = s.status_reg;
    assign o_PROC_RETURN = s.procedure_return_reg;
    assign o_FP_COMM = s.fp_communication_reg;
    assign o_FP_STATUS = s.fp_status_control_reg;
    // mode fields taken from the FP status register
    assign o_FP_MODE = '{
        precision: s.fp_status_control_reg[sysmove_pkg::FP_PREC_BIT],
        denorm_zero: s.fp_status_control_reg[sysmove_pkg::FP_DENORM_ZERO_BIT],
        bank: s.fp_status_control_reg[sysmove_pkg::FP_BANK_BIT],
        round: s.fp_status_control_reg[sysmove_pkg::FP_ROUND_BIT]};

    // Checks on the registered behaviour
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!rst_n);

    logic legal;
    assign legal = !(s.in_slot && i_IS_BRANCH) && !(dec.priv && user_mode);

    chk_call_target: assert property (
        accept && legal && !s.in_slot && dec.kind == sysmove_pkg::OP_CALL
        |=> o_PC_LOAD && o_PC_TARGET == $past(i_REG_DATA) &&
            o_PROC_RETURN == $past(i_PC) + sysmove_pkg::RETURN_OFFSET)
        else $error("call target or return address wrong");
    chk_slot_guard: assert property (
        (accept && legal && !s.in_slot && dec.kind == sysmove_pkg::OP_CALL) ||
        (o_INT_BLOCK && !accept) |=> o_INT_BLOCK)
        else $error("interrupt guard dropped early");
    chk_slot_branch: assert property (
        accept && s.in_slot && i_IS_BRANCH
        |=> o_EXC.slot_illegal && !o_GR_WE && !o_PC_LOAD && !o_MEM_REQ)
        else $error("branch in slot not refused");
    chk_sr_time: assert property (
        accept && legal && !s.in_slot && !dec.mem &&
        dec.kind == sysmove_pkg::OP_LOAD_STATUS
        |=> !o_READY [*3] ##1 (o_READY && o_DONE))
        else $error("status load time wrong");
    chk_priv_user: assert property (
        accept && dec.priv && user_mode && !(s.in_slot && i_IS_BRANCH)
        |=> (o_EXC.gen_illegal ^ o_EXC.slot_illegal) && !o_GR_WE &&
            !o_MEM_REQ && $stable(o_STATUS))
        else $error("privileged form ran in user mode");
    chk_fp_mask: assert property (
        (o_FP_STATUS & ~sysmove_pkg::FP_STATUS_WRITE_MASK) == 32'h0)
        else $error("FP status high bits set");
    chk_store_mask: assert property (
        o_MEM_REQ && o_MEM_WE && s.op.kind == sysmove_pkg::OP_STORE_FPSTAT
        |-> (o_MEM_WDATA & ~sysmove_pkg::FP_STATUS_WRITE_MASK) == 32'h0)
        else $error("FP status stored unmasked");
    chk_fp_mode: assert property (
        accept && legal && !dec.mem && dec.kind == sysmove_pkg::OP_LOAD_FPSTAT
        |=> o_FP_MODE.precision == $past(i_REG_DATA[19]) &&
            o_FP_MODE.bank == $past(i_REG_DATA[21]))
        else $error("FP mode bits wrong");
    chk_align_err: assert property (
        accept && legal && dec.mem && addr[1:0] != 2'h0
        |=> o_EXC.addr_err && !o_MEM_REQ && !o_GR_WE)
        else $error("misaligned access not refused");
    chk_fault_base: assert property (
        s.state == ST_MEM && i_MEM_ACK && fault != '0
        |=> !o_GR_WE && o_DONE)
        else $error("base written after fault");
    chk_load_page: assert property (
        s.state == ST_MEM && i_MEM_ACK && !s.op.store
        |=> !o_EXC.init_write)
        else $error("page write flagged on load");

    cov_call_slot: cover property (
        accept && dec.kind == sysmove_pkg::OP_CALL ##1
        !accept [*2] ##1 accept);
    cov_mem_store: cover property (o_MEM_REQ && o_MEM_WE ##[1:20] o_DONE);
    cov_mem_fault: cover property (
        s.state == ST_MEM && i_MEM_ACK && fault != '0);
    cov_sr_load: cover property (s.state == ST_HOLD ##1 s.state == ST_HOLD);

endmodule

// ==== include/sysmove_pkg.sv ====
// Shared constants and types for the call and system-register move unit
package sysmove_pkg;

    // Opcode match: high nibble and low byte, register field in [11:8]
    localparam logic [15:0] OPC_MASK = 16'hf0ff;
    localparam logic [15:0] OPC_CALL = 16'h400b;
    localparam logic [15:0] OPC_LOAD_STATUS = 16'h400e;
    localparam logic [15:0] OPC_LOAD_STATUS_MEM = 16'h4007;
    localparam logic [15:0] OPC_LOAD_COMM = 16'h405a;
    localparam logic [15:0] OPC_LOAD_COMM_MEM = 16'h4056;
    localparam logic [15:0] OPC_LOAD_FPSTAT = 16'h406a;
    localparam logic [15:0] OPC_LOAD_FPSTAT_MEM = 16'h4066;
    localparam logic [15:0] OPC_STORE_STATUS = 16'h0002;
    localparam logic [15:0] OPC_STORE_STATUS_MEM = 16'h4003;
    localparam logic [15:0] OPC_STORE_COMM = 16'h005a;
    localparam logic [15:0] OPC_STORE_FPSTAT = 16'h006a;
    localparam logic [15:0] OPC_STORE_COMM_MEM = 16'h4052;
    localparam logic [15:0] OPC_STORE_FPSTAT_MEM = 16'h4062;
    localparam int REG_FIELD_LSB = 8;

    // Floating-point status write mask and mode bit positions
    localparam logic [31:0] FP_STATUS_WRITE_MASK = 32'h003fffff;
    localparam int FP_PREC_BIT = 19;
    localparam int FP_DENORM_ZERO_BIT = 18;
    localparam int FP_BANK_BIT = 21;
    localparam int FP_ROUND_BIT = 0;

    // Status register layout and reset
    localparam int STATUS_MODE_BIT = 30;
    localparam logic [31:0] STATUS_RESET = 32'h40000000;

    // Address arithmetic and timing
    localparam logic [31:0] WORD_BYTES = 32'h00000004;
    localparam logic [31:0] RETURN_OFFSET = 32'h00000004;
    localparam int STATUS_LOAD_CYCLES = 4;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_CALL = 4'h1,
        OP_LOAD_STATUS = 4'h2,
        OP_LOAD_COMM = 4'h3,
        OP_LOAD_FPSTAT = 4'h4,
        OP_STORE_STATUS = 4'h5,
        OP_STORE_COMM = 4'h6,
        OP_STORE_FPSTAT = 4'h7
    } op_kind_t;

    typedef struct packed {
        op_kind_t kind;
        logic mem;
        logic store;
        logic priv;
        logic [3:0] reg_idx;
    } dec_t;

    typedef struct packed {
        logic multi_hit;
        logic miss;
        logic protect;
        logic init_write;
    } fault_t;

    typedef struct packed {
        logic slot_illegal;
        logic gen_illegal;
        logic multi_hit;
        logic miss;
        logic protect;
        logic init_write;
        logic addr_err;
    } exc_t;

    typedef struct packed {
        logic precision;
        logic denorm_zero;
        logic bank;
        logic round;
    } fp_mode_t;

endpackage

// ==== logic/sysmove_decode.sv ====
// Opcode decoder for the call and system-register move instructions
module sysmove_decode (
    input wire logic [15:0] i_opcode,
    output sysmove_pkg::dec_t o_dec
);

    // Pattern compare with the register field masked out
    function automatic logic hit(input logic [15:0] op, input logic [15:0] p);
        hit = (op & sysmove_pkg::OPC_MASK) == p;
    endfunction

    // One table entry per form; store follows the kind and memory form, privilege the kind
    always_comb begin
        o_dec = '0;
        o_dec.reg_idx = i_opcode[sysmove_pkg::REG_FIELD_LSB +: 4];
        if (hit(i_opcode, sysmove_pkg::OPC_CALL)) begin
            o_dec.kind = sysmove_pkg::OP_CALL;
        end else if (hit(i_opcode, sysmove_pkg::OPC_LOAD_STATUS) ||
                     hit(i_opcode, sysmove_pkg::OPC_LOAD_STATUS_MEM)) begin
            o_dec.kind = sysmove_pkg::OP_LOAD_STATUS;
            o_dec.mem = hit(i_opcode, sysmove_pkg::OPC_LOAD_STATUS_MEM);
        end else if (hit(i_opcode, sysmove_pkg::OPC_LOAD_COMM) ||
                     hit(i_opcode, sysmove_pkg::OPC_LOAD_COMM_MEM)) begin
            o_dec.kind = sysmove_pkg::OP_LOAD_COMM;
            o_dec.mem = hit(i_opcode, sysmove_pkg::OPC_LOAD_COMM_MEM);
        end else if (hit(i_opcode, sysmove_pkg::OPC_LOAD_FPSTAT) ||
                     hit(i_opcode, sysmove_pkg::OPC_LOAD_FPSTAT_MEM)) begin
            o_dec.kind = sysmove_pkg::OP_LOAD_FPSTAT;
            o_dec.mem = hit(i_opcode, sysmove_pkg::OPC_LOAD_FPSTAT_MEM);
        end else if (hit(i_opcode, sysmove_pkg::OPC_STORE_STATUS) ||
                     hit(i_opcode, sysmove_pkg::OPC_STORE_STATUS_MEM)) begin
            o_dec.kind = sysmove_pkg::OP_STORE_STATUS;
            o_dec.mem = hit(i_opcode, sysmove_pkg::OPC_STORE_STATUS_MEM);
        end else if (hit(i_opcode, sysmove_pkg::OPC_STORE_COMM) ||
                     hit(i_opcode, sysmove_pkg::OPC_STORE_COMM_MEM)) begin
            o_dec.kind = sysmove_pkg::OP_STORE_COMM;
            o_dec.mem = hit(i_opcode, sysmove_pkg::OPC_STORE_COMM_MEM);
        end else if (hit(i_opcode, sysmove_pkg::OPC_STORE_FPSTAT) ||
                     hit(i_opcode, sysmove_pkg::OPC_STORE_FPSTAT_MEM)) begin
            o_dec.kind = sysmove_pkg::OP_STORE_FPSTAT;
            o_dec.mem = hit(i_opcode, sysmove_pkg::OPC_STORE_FPSTAT_MEM);
        end
        o_dec.store = o_dec.mem &&
                      (o_dec.kind == sysmove_pkg::OP_STORE_STATUS ||
                       o_dec.kind == sysmove_pkg::OP_STORE_COMM ||
                       o_dec.kind == sysmove_pkg::OP_STORE_FPSTAT);
        o_dec.priv = o_dec.kind == sysmove_pkg::OP_LOAD_STATUS ||
                     o_dec.kind == sysmove_pkg::OP_STORE_STATUS;
    end

endmodule

// ==== tb/sysmove_mem_model.sv ====
// Behavioural data memory answering the unit's longword requests
module sysmove_mem_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [31:0] i_addr,
    input wire logic [3:0] i_lat,
    input wire sysmove_pkg::fault_t i_flt,
    output logic o_ack,
    output logic [31:0] o_rdata,
    output sysmove_pkg::fault_t o_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    // Single ack after the wait; idle data toggles so stale values never match
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_cnt <= 4'h0;
            o_ack <= 1'b0;
            o_rdata <= 32'h0;
            o_fault <= '0;
        end else if (i_req && !o_ack && wait_cnt >= i_lat) begin
            o_ack <= 1'b1;
            o_rdata <= i_we ? ~o_rdata : {i_addr[15:0], ~i_addr[15:0]};
            o_fault <= i_flt;
            wait_cnt <= 4'h0;
        end else begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            o_fault <= '0;
            wait_cnt <= (i_req && !o_ack) ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule

// ==== tb/subroutine_call_sysreg_moves_test.sv ====
// Self-checking bench for the call and system-register move unit
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module subroutine_call_sysreg_moves_test;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] op;
        logic [31:0] rd;
        int cyc;
        int sel;
        logic [31:0] res;
    } row_t;
    logic I_MCLK, I_RESET_N, vld, br, ack, rdy, done, gwe, pcl, intb;
    logic mreq, mwe, c_req, c_gwe, c_pcl, c_we;
    logic [3:0] gidx, lat, c_gidx;
    logic [15:0] opc;
    logic [31:0] pc, rd, mrd, gdata, pct, maddr, mwd, sr, pr, fpc, fps;
    logic [31:0] c_gdata, c_pct, c_addr, c_wd, obs;
    sysmove_pkg::exc_t exc, c_exc;
    sysmove_pkg::fp_mode_t mode;
    sysmove_pkg::fault_t flt, mflt;
    int n, miscompares, n_compared;
    // Register forms: result lands in Rn (sel 0), FP_COMMUNICATION_REG, FP_STATUS_CONTROL_REG or status
    row_t rows[6] = '{
        '{16'h415a, 32'h12abcdef, 1, 1, 32'h12abcdef},
        '{16'h025a, 32'h0, 1, 0, 32'h12abcdef},
        '{16'h436a, 32'hffe80001, 1, 2, 32'h00280001},
        '{16'h046a, 32'h0, 1, 0, 32'h00280001},
        '{16'h0502, 32'h0, 1, 0, 32'h40000000},
        '{16'h460e, 32'h40000301, 4, 3, 32'h40000301}};
    sysmove_unit sysmove_unit_inst (.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N),
        .i_VALID(vld), .i_OPCODE(opc), .i_PC(pc), .i_REG_DATA(rd),
        .i_IS_BRANCH(br), .i_MEM_ACK(ack), .i_MEM_RDATA(mrd),
        .i_MEM_FAULT(mflt), .o_READY(rdy), .o_DONE(done), .o_GR_WE(gwe),
        .o_GR_IDX(gidx), .o_GR_DATA(gdata), .o_PC_LOAD(pcl),
        .o_PC_TARGET(pct), .o_INT_BLOCK(intb), .o_EXC(exc), .o_MEM_REQ(mreq),
        .o_MEM_WE(mwe), .o_MEM_ADDR(maddr), .o_MEM_WDATA(mwd), .o_STATUS(sr),
        .o_PROC_RETURN(pr), .o_FP_COMM(fpc), .o_FP_STATUS(fps),
        .o_FP_MODE(mode));
    sysmove_mem_model sysmove_mem_model_inst (.i_clk(I_MCLK),
        .i_rst_n(I_RESET_N), .i_req(mreq), .i_we(mwe), .i_addr(maddr),
        .i_lat(lat), .i_flt(flt), .o_ack(ack), .o_rdata(mrd),
        .o_fault(mflt));
    // Free-running core clock, 4 ns period
    initial begin
        I_MCLK = 1'b0;
        forever #2 I_MCLK = ~I_MCLK;
    end
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One instruction, bounded wait for done; memory request seen en route
    task automatic exec(input logic [15:0] op, input logic [31:0] r,
                        input logic b);
        c_req = 1'b0;
        c_we = 1'b0;
        @(posedge I_MCLK);
        vld <= 1'b1;
        opc <= op;
        rd <= r;
        br <= b;
        @(posedge I_MCLK);
        vld <= 1'b0;
        n = 0;
        // Look just after each edge; done stands one cycle only
        do begin
            #1;
            n++;
            if (mreq === 1'b1) begin
                c_req = 1'b1;
                c_we = mwe;
                c_addr = maddr;
                c_wd = mwd;
            end
            if (done !== 1'b1) begin
                @(posedge I_MCLK);
            end
        end while (done !== 1'b1 && n < 50);
        c_gwe = gwe;
        c_gidx = gidx;
        c_gdata = gdata;
        c_exc = exc;
        c_pcl = pcl;
        c_pct = pct;
        if (n >= 50) begin
            miscompares++;
            end_sim();
        end
    endtask
    // Main sequence: reset, table rows, then hand-written cases
    initial begin
        {vld, br, opc, pc, rd, flt, miscompares, n_compared} = '0;
        lat = 4'h0;
        I_RESET_N = 1'b0;
        repeat (5) @(posedge I_MCLK);
        I_RESET_N <= 1'b1;
        `CHK(sr, sysmove_pkg::STATUS_RESET)
        repeat (2) @(posedge I_MCLK);
        for (int i = 0; i < 6; i++) begin
            exec(rows[i].op, rows[i].rd, 1'b0);
            `CHK(n, rows[i].cyc)
            obs = rows[i].sel == 0 ? c_gdata : rows[i].sel == 1 ? fpc :
                  rows[i].sel == 2 ? fps : sr;
            `CHK(obs, rows[i].res)
        end
        `CHK(mode, 4'b1011)
        @(posedge I_MCLK);
        pc <= 32'h1000;
        exec(16'h470b, 32'h2000, 1'b0);
        `CHK({c_pcl, intb}, 2'b11)
        `CHK({c_pct, pr}, {32'h2000, 32'h1004})
        exec(16'h400b, 32'h3000, 1'b1);
        `CHK({c_exc.slot_illegal, c_pcl, intb}, 3'b100)
        lat = 4'h2;
        exec(16'h4862, 32'h0c700154, 1'b0);
        `CHK({c_addr, c_gdata}, {32'h0c700150, 32'h0c700150})
        `CHK(c_wd, 32'h00280001)
        `CHK({c_gidx, c_we}, 5'h11)
        exec(16'h4966, 32'h00000100, 1'b0);
        `CHK({fps, c_gdata}, {32'h0000feff, 32'h00000104})
        `CHK({c_we, c_gidx}, 5'h09)
        exec(16'h4a03, 32'h00000102, 1'b0);
        `CHK({c_exc.addr_err, c_req, c_gwe}, 3'b100)
        flt.miss = 1'b1;
        exec(16'h4b07, 32'h00000200, 1'b0);
        `CHK({c_exc.miss, c_gwe, sr}, {2'b10, 32'h40000301})
        flt = '0;
        flt.init_write = 1'b1;
        exec(16'h4c52, 32'h00000300, 1'b0);
        `CHK({c_exc.init_write, c_gwe}, 2'b10)
        flt = '0;
        exec(16'h4d0e, 32'h00000000, 1'b0);
        exec(16'h0e02, 32'h0, 1'b0);
        `CHK({c_exc.gen_illegal, c_gwe}, 2'b10)
        exec(16'h4e0e, 32'h40000000, 1'b0);
        `CHK({c_exc.gen_illegal, sr}, {1'b1, 32'h0})
        // Reset in mid-run must bring back the privileged status value
        @(posedge I_MCLK);
        I_RESET_N <= 1'b0;
        repeat (2) @(posedge I_MCLK);
        `CHK({sr, rdy, intb}, {sysmove_pkg::STATUS_RESET, 2'b10})
        end_sim();
    end
endmodule
